// ---- rtl/hpcfg_regs.sv ----
// hub port power configuration registers 08h..0ch and their effects
`timescale 1ns/100ps

// Functional notes
// - dynamic bit set: follow local power loss into bus power and back; clear: power mode follows STATIC_SELF_POWERED
// - delay field bits 5:4 chooses 0.1ms, 2ms, 4ms or 6ms over-current delay
// - compound bit 3 marks hub as part of compound device
// - bits 1..4 of fixed-port register flag ports with non-removable devices
// - self-powered mask bits 1..4 disable ports while self-powered
// - bus-powered mask bits 1..4 disable ports while bus-powered
// - bit 0 of port registers reads zero; bits 7..5 reserved
// - current limit reported in 2mA units, 50 means 100mA
// - all five registers are eight bits and reset to zero
// - undefined offsets read zero; writes there are silently ignored
module hpcfg_regs #(
    parameter int OCD_CYCLES_0 = hpcfg_pkg::OCD_C0,
    parameter int OCD_CYCLES_1 = hpcfg_pkg::OCD_C1,
    parameter int OCD_CYCLES_2 = hpcfg_pkg::OCD_C2,
    parameter int OCD_CYCLES_3 = hpcfg_pkg::OCD_C3
) (
    // clock and reset
    input  wire logic        REF_CLK,
    input  wire logic        RESETN,
    // register port from the configuration loader
    input  wire logic [7:0]  REG_ADDR,
    input  wire logic        REG_WRITE,
    input  wire logic [7:0]  REG_WDATA,
    input  wire logic        REG_READ,
    output logic      [7:0]  REG_RDATA,
    // power inputs
    input  wire logic        LOCAL_POWER_OK,
    input  wire logic        STATIC_SELF_POWERED,
    // configuration outputs
    output logic             SELF_POWERED,
    output logic             DYNAMIC_ENABLE,
    output logic [1:0]       OVERCURRENT_DELAY_SELECT,
    output logic [31:0]      OVERCURRENT_DELAY_CYCLES,
    output logic             COMPOUND_DEVICE,
    output logic [3:0]       FIXED_PORT_MASK,
    output logic [3:0]       PORT_OFF,
    output logic [7:0]       SELF_POWERED_CURRENT_UNITS,
    output logic [9:0]       SELF_POWERED_CURRENT_MA
);
    hpcfg_pkg::hpcfg_state_s st;
    hpcfg_pkg::hpcfg_state_s next_st;

    function automatic logic [7:0] read_mux(input hpcfg_pkg::hpcfg_state_s s, input logic [7:0] a);
        unique case (a)
            hpcfg_pkg::ADDR_POWER_OPTIONS: read_mux = s.power_options;
            hpcfg_pkg::ADDR_FIXED_PORTS:   read_mux = s.fixed_ports & hpcfg_pkg::PORT_FIELD_MASK;
            hpcfg_pkg::ADDR_SP_PORT_OFF:   read_mux = s.sp_port_off & hpcfg_pkg::PORT_FIELD_MASK;
            hpcfg_pkg::ADDR_BP_PORT_OFF:   read_mux = s.bp_port_off & hpcfg_pkg::PORT_FIELD_MASK;
            hpcfg_pkg::ADDR_SP_CURRENT:    read_mux = s.sp_current;
            default:                       read_mux = 8'h00;
        endcase
    endfunction : read_mux

    always_comb begin
        next_st = st;
        next_st.loss_sync1 = ~LOCAL_POWER_OK;
        next_st.loss_sync2 = st.loss_sync1;
        // reserved bits are stored masked so a careless host cannot light them
        if (REG_WRITE) begin
            unique case (REG_ADDR)
                hpcfg_pkg::ADDR_POWER_OPTIONS: next_st.power_options = REG_WDATA & hpcfg_pkg::POWER_OPTIONS_MASK;
                hpcfg_pkg::ADDR_FIXED_PORTS:   next_st.fixed_ports = REG_WDATA & hpcfg_pkg::PORT_FIELD_MASK;
                hpcfg_pkg::ADDR_SP_PORT_OFF:   next_st.sp_port_off = REG_WDATA & hpcfg_pkg::PORT_FIELD_MASK;
                hpcfg_pkg::ADDR_BP_PORT_OFF:   next_st.bp_port_off = REG_WDATA & hpcfg_pkg::PORT_FIELD_MASK;
                hpcfg_pkg::ADDR_SP_CURRENT:    next_st.sp_current = REG_WDATA;
                default: ;
            endcase
        end
        if (REG_READ) begin
            next_st.rdata = read_mux(st, REG_ADDR);
        end
        if (st.power_options[hpcfg_pkg::DYNAMIC_BIT]) begin
            next_st.self_powered = ~st.loss_sync2;
        end else begin
            next_st.self_powered = STATIC_SELF_POWERED;
        end
        if (st.self_powered) begin
            next_st.port_off = st.sp_port_off[hpcfg_pkg::PORT_LSB +: hpcfg_pkg::NUM_PORTS];
        end else begin
            next_st.port_off = st.bp_port_off[hpcfg_pkg::PORT_LSB +: hpcfg_pkg::NUM_PORTS];
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RESETN) begin
            st.power_options <= hpcfg_pkg::REG_RESET;
            st.fixed_ports   <= hpcfg_pkg::REG_RESET;
            st.sp_port_off   <= hpcfg_pkg::REG_RESET;
            st.bp_port_off   <= hpcfg_pkg::REG_RESET;
            st.sp_current    <= hpcfg_pkg::REG_RESET;
            st.rdata         <= 8'h00;
            st.loss_sync1    <= 1'b0;
            st.loss_sync2    <= 1'b0;
            st.self_powered  <= 1'b0;
            st.port_off      <= 4'h0;
        end else begin
            st <= next_st;
        end
    end

    always_comb begin
        unique case (OVERCURRENT_DELAY_SELECT)
            2'b00: OVERCURRENT_DELAY_CYCLES = 32'(OCD_CYCLES_0);
            2'b01: OVERCURRENT_DELAY_CYCLES = 32'(OCD_CYCLES_1);
            2'b10: OVERCURRENT_DELAY_CYCLES = 32'(OCD_CYCLES_2);
            2'b11: OVERCURRENT_DELAY_CYCLES = 32'(OCD_CYCLES_3);
        endcase
    end

    assign REG_RDATA                  = st.rdata;
    assign SELF_POWERED               = st.self_powered;
    assign DYNAMIC_ENABLE             = st.power_options[hpcfg_pkg::DYNAMIC_BIT];
    assign OVERCURRENT_DELAY_SELECT   = st.power_options[hpcfg_pkg::OCD_LSB +: 2];
    assign COMPOUND_DEVICE            = st.power_options[hpcfg_pkg::COMPOUND_BIT];
    assign FIXED_PORT_MASK            = st.fixed_ports[hpcfg_pkg::PORT_LSB +: hpcfg_pkg::NUM_PORTS];
    assign PORT_OFF                   = st.port_off;
    assign SELF_POWERED_CURRENT_UNITS = st.sp_current;
    assign SELF_POWERED_CURRENT_MA    = {1'b0, st.sp_current, 1'b0};
endmodule : hpcfg_regs

// ---- rtl/hpcfg_pkg.sv ----
// package for the hub port power configuration register bank
package hpcfg_pkg;
    localparam logic [7:0] ADDR_POWER_OPTIONS = 8'h08;
    localparam logic [7:0] ADDR_FIXED_PORTS   = 8'h09;
    localparam logic [7:0] ADDR_SP_PORT_OFF   = 8'h0a;
    localparam logic [7:0] ADDR_BP_PORT_OFF   = 8'h0b;
    localparam logic [7:0] ADDR_SP_CURRENT    = 8'h0c;
    localparam logic [7:0] REG_RESET          = 8'h00;
    localparam int         DYNAMIC_BIT        = 7;
    localparam int         COMPOUND_BIT       = 3;
    localparam int         OCD_LSB            = 4;
    localparam logic [7:0] POWER_OPTIONS_MASK = 8'hb8;
    localparam logic [7:0] PORT_FIELD_MASK    = 8'h1e;
    localparam int         PORT_LSB           = 1;
    localparam int         NUM_PORTS          = 4;
    localparam int         CLK_MHZ            = 200;
    // over-current delays in microseconds, as printed
    localparam int OCD_T0_US = 100;
    localparam int OCD_T1_US = 2000;
    localparam int OCD_T2_US = 4000;
    localparam int OCD_T3_US = 6000;
    localparam int OCD_C0 = OCD_T0_US * CLK_MHZ;
    localparam int OCD_C1 = OCD_T1_US * CLK_MHZ;
    localparam int OCD_C2 = OCD_T2_US * CLK_MHZ;
    localparam int OCD_C3 = OCD_T3_US * CLK_MHZ;
    localparam int CURRENT_UNIT_MA = 2;

    typedef struct packed {
        logic [7:0] power_options;
        logic [7:0] fixed_ports;
        logic [7:0] sp_port_off;
        logic [7:0] bp_port_off;
        logic [7:0] sp_current;
        logic [7:0] rdata;
        logic       loss_sync1;
        logic       loss_sync2;
        logic       self_powered;
        logic [NUM_PORTS-1:0] port_off;
    } hpcfg_state_s;
endpackage : hpcfg_pkg

// ---- bench/hpcfg_chk.sv ----
// assertions on the port power configuration register bank
`timescale 1ns/100ps
module hpcfg_chk #(parameter int OCD_CYCLES_0 = 1, OCD_CYCLES_1 = 1, OCD_CYCLES_2 = 1, OCD_CYCLES_3 = 1) (
    input wire logic REF_CLK, RESETN, REG_WRITE, REG_READ, LOCAL_POWER_OK, STATIC_SELF_POWERED,
    input wire logic SELF_POWERED, DYNAMIC_ENABLE, COMPOUND_DEVICE,
    input wire logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA, SELF_POWERED_CURRENT_UNITS,
    input wire logic [1:0] OVERCURRENT_DELAY_SELECT, input wire logic [31:0] OVERCURRENT_DELAY_CYCLES,
    input wire logic [3:0] FIXED_PORT_MASK, PORT_OFF, input wire logic [9:0] SELF_POWERED_CURRENT_MA
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RESETN);
    sequence wr_at(a); REG_WRITE && REG_ADDR == a; endsequence
    sequence power_steady; (DYNAMIC_ENABLE && $stable(LOCAL_POWER_OK))[*4]; endsequence
    chk_power_opts: assert property (wr_at(8'h08) |=> DYNAMIC_ENABLE == $past(REG_WDATA[7]))
        else $error("dynamic bit not taken");
    chk_dyn_follow: assert property (power_steady |-> SELF_POWERED == LOCAL_POWER_OK)
        else $error("power mode does not follow local power");
    chk_delay_map: assert property (OVERCURRENT_DELAY_CYCLES == (OVERCURRENT_DELAY_SELECT == 2'h0 ? OCD_CYCLES_0 :
        OVERCURRENT_DELAY_SELECT == 2'h1 ? OCD_CYCLES_1 : OVERCURRENT_DELAY_SELECT == 2'h2 ? OCD_CYCLES_2 : OCD_CYCLES_3))
        else $error("delay count does not match select");
    chk_compound_flag: assert property (wr_at(8'h08) |=> COMPOUND_DEVICE == $past(REG_WDATA[3]))
        else $error("compound flag not taken");
    chk_fixed_ports: assert property (wr_at(8'h09) |=> FIXED_PORT_MASK == $past(REG_WDATA[4:1]))
        else $error("fixed port mask not taken");
    chk_port_reserved: assert property (REG_READ && REG_ADDR inside {[8'h09:8'h0b]} |=> (REG_RDATA & 8'he1) == 8'h00)
        else $error("reserved port bits read nonzero");
    chk_current_ma: assert property (SELF_POWERED_CURRENT_MA == {SELF_POWERED_CURRENT_UNITS, 1'b0})
        else $error("current not in 2mA units");
    chk_undef_zero: assert property (REG_READ && !(REG_ADDR inside {[8'h08:8'h0c]}) |=> REG_RDATA == 8'h00)
        else $error("undefined offset read nonzero");
endmodule : hpcfg_chk
bind hpcfg_regs hpcfg_chk #(.OCD_CYCLES_0(OCD_CYCLES_0), .OCD_CYCLES_1(OCD_CYCLES_1), .OCD_CYCLES_2(OCD_CYCLES_2),
    .OCD_CYCLES_3(OCD_CYCLES_3)) hpcfg_chk_i (.*);

// ---- bench/hpcfg_host.sv ----
// configuration host model loading the register bank
`timescale 1ns/100ps
module hpcfg_host (
    input wire logic REF_CLK, input wire logic [7:0] REG_RDATA,
    output logic REG_WRITE = 1'b0, REG_READ = 1'b0, output logic [7:0] REG_ADDR = 8'h00, REG_WDATA = 8'h00
);
    logic obey = 1'b1;
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        if (obey && a inside {8'h09, 8'h0a, 8'h0b}) d = d & 8'h1e;
        if (obey && a == 8'h0c && d > 8'h32) d = 8'h32;
        @(negedge REF_CLK);
        {REG_ADDR, REG_WDATA, REG_WRITE} = {a, d, 1'b1};
        @(negedge REF_CLK);
        {REG_WDATA, REG_WRITE} = {~d, 1'b0};
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge REF_CLK);
        {REG_ADDR, REG_READ} = {a, 1'b1};
        @(negedge REF_CLK);
        REG_READ = 1'b0;
        d = REG_RDATA;
    endtask : rd
endmodule : hpcfg_host

// ---- bench/test_hub_port_power_config_regs.sv ----
// self-checking bench for the port power configuration register bank
`timescale 1ns/100ps
module test_hub_port_power_config_regs;
    logic REF_CLK = 1'b0, RESETN = 1'b0, LOCAL_POWER_OK = 1'b1, STATIC_SELF_POWERED = 1'b1;
    logic REG_WRITE, REG_READ, SELF_POWERED, DYNAMIC_ENABLE, COMPOUND_DEVICE;
    logic [7:0] REG_ADDR, REG_WDATA, REG_RDATA, SELF_POWERED_CURRENT_UNITS, rv;
    logic [1:0] OVERCURRENT_DELAY_SELECT;
    logic [31:0] OVERCURRENT_DELAY_CYCLES;
    logic [3:0] FIXED_PORT_MASK, PORT_OFF;
    logic [9:0] SELF_POWERED_CURRENT_MA;
    int err_count = 0, num_checks = 0;
    localparam int OCD [4] = '{2, 4, 6, 8};
    always #2.5 REF_CLK = ~REF_CLK;
    hpcfg_regs #(.OCD_CYCLES_0(OCD[0]), .OCD_CYCLES_1(OCD[1]), .OCD_CYCLES_2(OCD[2]), .OCD_CYCLES_3(OCD[3]))
        hpcfg_regs_i (.*);
    hpcfg_host hpcfg_host_i (.*);
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic finish_test;
        if (err_count == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : finish_test
    task automatic t_fields;
        for (int a = 8; a <= 12; a++) begin
            hpcfg_host_i.rd(8'(a), rv);
            check(rv, 8'h00);
        end
        hpcfg_host_i.obey = 1'b0;
        for (int a = 8; a <= 11; a++) begin
            hpcfg_host_i.wr(8'(a), 8'hff);
            hpcfg_host_i.rd(8'(a), rv);
            check(rv, a == 8 ? 8'hb8 : 8'h1e);
        end
        check({COMPOUND_DEVICE, FIXED_PORT_MASK}, 5'h1f);
        hpcfg_host_i.obey = 1'b1;
        for (int s = 0; s < 4; s++) begin
            hpcfg_host_i.wr(8'h08, 8'(s << 4));
            check(OVERCURRENT_DELAY_SELECT, 32'(s));
            check(OVERCURRENT_DELAY_CYCLES, 32'(OCD[s]));
        end
    endtask : t_fields
    task automatic t_power;
        hpcfg_host_i.wr(8'h0a, 8'h06);
        hpcfg_host_i.wr(8'h0b, 8'h18);
        repeat (2) @(negedge REF_CLK);
        check({SELF_POWERED, PORT_OFF}, 5'h13);
        STATIC_SELF_POWERED = 1'b0;
        repeat (3) @(negedge REF_CLK);
        check({SELF_POWERED, PORT_OFF}, 5'h0c);
        {STATIC_SELF_POWERED, LOCAL_POWER_OK} = 2'h2;
        hpcfg_host_i.wr(8'h08, 8'h80);
        repeat (5) @(negedge REF_CLK);
        check({SELF_POWERED, PORT_OFF}, 5'h0c);
        LOCAL_POWER_OK = 1'b1;
        repeat (5) @(negedge REF_CLK);
        check({SELF_POWERED, PORT_OFF}, 5'h13);
        hpcfg_host_i.wr(8'h08, 8'h00);
        LOCAL_POWER_OK = 1'b0;
        repeat (5) @(negedge REF_CLK);
        check(SELF_POWERED, 1'b1);
    endtask : t_power
    task automatic t_misc;
        hpcfg_host_i.wr(8'h0c, 8'h32);
        hpcfg_host_i.wr(8'h0d, 8'h5a);
        hpcfg_host_i.rd(8'h0d, rv);
        check(rv, 8'h00);
        hpcfg_host_i.rd(8'h0c, rv);
        check({SELF_POWERED_CURRENT_MA, rv}, 18'h06432);
        check(SELF_POWERED_CURRENT_UNITS, 8'h32);
        // a reset in mid-run must clear what the host loaded
        @(negedge REF_CLK);
        RESETN = 1'b0;
        @(negedge REF_CLK);
        RESETN = 1'b1;
        hpcfg_host_i.rd(8'h0c, rv);
        check(rv, 8'h00);
    endtask : t_misc
    initial begin
        repeat (20) @(negedge REF_CLK);
        RESETN = 1'b1;
        t_fields();
        t_power();
        t_misc();
        finish_test();
    end
    initial begin
        #20000;
        err_count++;
        finish_test();
    end
endmodule : test_hub_port_power_config_regs
